// ---- iatm_defines.svh ----
`ifndef IATM_DEFINES_SVH
`define IATM_DEFINES_SVH

// Channel and sample geometry
`define IATM_NUM_CHAN 4
`define IATM_DATA_W 12
`define IATM_AVG_DEPTH 4

// Core clock and conversion timing
`define IATM_CLK_HZ 40000000
`define IATM_RATE_SPS 20000
`define IATM_CONV_CYC (`IATM_CLK_HZ / (`IATM_RATE_SPS * `IATM_NUM_CHAN))
`define IATM_RESP_TIME_US 75
`define IATM_RESP_CYC ((`IATM_RESP_TIME_US * `IATM_CLK_HZ) / 1000000)

// Serial frame layout
`define IATM_CMD_BITS 8
`define IATM_CMD_CHAN_LSB 0
`define IATM_RESP_BITS 16
`define IATM_CRC_BITS 8
`define IATM_CRC_POLY 8'h07
`define IATM_CRC_INIT 8'hFF
`define IATM_SYNC_STAGES 3

`endif

// ---- iatm_pkg.sv ----
`include "iatm_defines.svh"

package iatm_pkg;

  // One converted sample
  typedef logic [`IATM_DATA_W-1:0] iatm_sample_t;

  // Comparator behaviour per channel
  typedef enum logic {
    CMP_DIGITAL_INPUT,
    CMP_DIGITAL_STATUS
  } iatm_cmp_mode_t;

  // Serial port sequencing
  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_CMD,
    SPI_DATA
  } iatm_spi_state_t;

endpackage : iatm_pkg

// ---- iatm_chan_if.sv ----
`timescale 1ns/10ps

interface iatm_chan_if;
  import iatm_pkg::*;

  logic sample_valid;
  iatm_sample_t sample_data;
  logic filter_en;
  logic filter_clear;
  iatm_cmp_mode_t mode;
  iatm_sample_t thr_upper;
  iatm_sample_t thr_lower;
  iatm_sample_t raw;
  iatm_sample_t avg;
  logic cmp_out;
  logic crossing;

  modport ctrl (
    output sample_valid, sample_data, filter_en, filter_clear, mode, thr_upper, thr_lower,
    input raw, avg, cmp_out, crossing
  );

  modport chan (
    input sample_valid, sample_data, filter_en, filter_clear, mode, thr_upper, thr_lower,
    output raw, avg, cmp_out, crossing
  );

endinterface : iatm_chan_if

// ---- iatm_crc.sv ----
`timescale 1ns/10ps

module iatm_crc #(
  parameter int W = `IATM_RESP_BITS
) (
  // Word to protect, MSB first
  input wire logic [W-1:0] data,
  // Check byte
  output logic [`IATM_CRC_BITS-1:0] crc
);
  import iatm_pkg::*;

  // Bitwise CRC-8; unrolled by the loop, one level of logic per bit
  always_comb begin
    logic [`IATM_CRC_BITS-1:0] c;
    logic fb;
    c = `IATM_CRC_INIT;
    fb = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      fb = c[`IATM_CRC_BITS-1] ^ data[i];
      c = {c[`IATM_CRC_BITS-2:0], 1'b0} ^ (fb ? `IATM_CRC_POLY : 8'h00);
    end
    crc = c;
  end

endmodule : iatm_crc

// ---- iatm_chan.sv ----
`timescale 1ns/10ps

module iatm_chan #(
  parameter int DATA_W = `IATM_DATA_W,
  parameter int DEPTH = `IATM_AVG_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Link to the core
  iatm_chan_if.chan bus
);
  import iatm_pkg::*;

  localparam int SW = DATA_W + $clog2(DEPTH);

  logic [DATA_W-1:0] hist [DEPTH];
  logic [SW-1:0] sum;
  logic [DATA_W-1:0] value;
  logic next_cmp;

  // Newest sample at index 0; history feeds the running average
  always_ff @(posedge core_clk) begin
    if (!nrst || bus.filter_clear) begin
      for (int i = 0; i < DEPTH; i++) hist[i] <= '0;
    end else if (bus.sample_valid) begin
      hist[0] <= bus.sample_data;
      for (int i = 1; i < DEPTH; i++) hist[i] <= hist[i-1];
    end
  end

  // Sum of the latest readings; depth is a power of two so divide is a shift
  always_comb begin
    sum = '0;
    for (int i = 0; i < DEPTH; i++) sum = sum + SW'(hist[i]);
  end

  // Comparator looks at the average only while filtering is on
  assign value = bus.filter_en ? sum[SW-1 -: DATA_W] : hist[0]; // [R8]

  // Registered copies of raw and filtered results for readout
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bus.raw <= '0;
      bus.avg <= '0;
    end else begin
      bus.raw <= hist[0];
      bus.avg <= sum[SW-1 -: DATA_W]; // [R4]
    end
  end

  // Window comparator with hysteresis; status mode follows the upper limit alone
  always_comb begin
    next_cmp = bus.cmp_out;
    if (bus.mode == CMP_DIGITAL_INPUT) begin
      if (value > bus.thr_upper) next_cmp = 1'b1; // [R6]
      else if (value < bus.thr_lower) next_cmp = 1'b0; // [R6]
      else next_cmp = bus.cmp_out; // [R7]
    end else begin
      next_cmp = value > bus.thr_upper;
    end
  end

  // Output level and a one-cycle pulse whenever it changes
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bus.cmp_out <= 1'b0;
      bus.crossing <= 1'b0;
    end else begin
      bus.cmp_out <= next_cmp; // [R5]
      bus.crossing <= next_cmp != bus.cmp_out; // [R9]
    end
  end

endmodule : iatm_chan

// ---- iatm_top.sv ----
`timescale 1ns/10ps

// Notes on behaviour
// R1 - four channels, one converter, 12-bit results
// R2 - each channel converted at 20 ksps
// R3 - host reads raw or filtered result
// R4 - filtered value averages four latest samples
// R5 - per-channel upper and lower thresholds
// R6 - output high above upper, low below lower
// R7 - between thresholds the output holds in input mode; in status mode it goes low
// R8 - filtering makes comparator use the average
// R9 - interrupt on any threshold crossing
// R10 - unfiltered comparator answers within 75 us
// R11 - optional check byte, generated and verified
module iatm_top #(
  parameter int NUM_CHAN = `IATM_NUM_CHAN,
  parameter int DATA_W = `IATM_DATA_W,
  parameter int CONV_CYC = `IATM_CONV_CYC,
  parameter int RESP_CYC = `IATM_RESP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Field-side converter
  output logic conv_req,
  output logic [$clog2(`IATM_NUM_CHAN)-1:0] conv_chan,
  input wire logic sample_valid,
  input wire logic [$clog2(`IATM_NUM_CHAN)-1:0] sample_chan,
  input wire iatm_pkg::iatm_sample_t sample_data,
  // Configuration
  input wire logic filter_en,
  input wire logic [`IATM_NUM_CHAN-1:0] filter_clear,
  input wire logic [`IATM_NUM_CHAN-1:0] comparator_mode_select,
  input wire iatm_pkg::iatm_sample_t [`IATM_NUM_CHAN-1:0] thr_upper,
  input wire iatm_pkg::iatm_sample_t [`IATM_NUM_CHAN-1:0] thr_lower,
  input wire logic crc_en,
  // Comparator pins and interrupt
  output logic [`IATM_NUM_CHAN-1:0] channel_compare_out,
  output logic [`IATM_NUM_CHAN-1:0] crossing_flags,
  input wire logic [`IATM_NUM_CHAN-1:0] crossing_clear,
  output logic irq_n,
  // Status
  output logic [`IATM_NUM_CHAN-1:0] sample_timeout,
  output logic crc_err,
  output logic frame_err,
  // Serial port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe
);
  import iatm_pkg::*;

  localparam int CHW = $clog2(NUM_CHAN);
  localparam int CW = $clog2(CONV_CYC);
  localparam int TW = $clog2(RESP_CYC + 1);
  localparam int CMD_BITS = `IATM_CMD_BITS;
  localparam int RESP_BITS = `IATM_RESP_BITS;
  localparam int CRC_BITS = `IATM_CRC_BITS;
  localparam int TX_BITS = RESP_BITS + CRC_BITS;
  localparam int BCW = 6;

  // Channel result views
  iatm_chan_if ch_if [NUM_CHAN] ();
  iatm_sample_t raw_a [NUM_CHAN];
  iatm_sample_t avg_a [NUM_CHAN];
  logic [NUM_CHAN-1:0] cross_a;

  // Conversion scheduler
  logic [CW-1:0] conv_cnt;

  // Pin synchronisers: index 0 clock, 1 select, 2 data
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_f;
  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_act;

  // Serial engine
  iatm_spi_state_t spi_state;
  logic [BCW-1:0] bit_cnt;
  logic [CMD_BITS-1:0] rx_sr;
  logic [CMD_BITS-1:0] cmd;
  logic [CMD_BITS-1:0] next_rx;
  logic [TX_BITS-1:0] tx_sr;
  logic [RESP_BITS-1:0] resp_word;
  logic [CRC_BITS-1:0] resp_crc;
  logic [CRC_BITS-1:0] cmd_crc;
  logic [CHW-1:0] rd_chan;
  logic frame_bad;

  // Round-robin conversion requests, one channel every CONV_CYC cycles
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      conv_cnt <= '0;
      conv_req <= 1'b0;
      conv_chan <= '0;
    end else begin
      conv_req <= 1'b0;
      if (conv_cnt == CW'(CONV_CYC - 1)) begin
        conv_cnt <= '0;
        conv_req <= 1'b1; // [R2]
        conv_chan <= conv_chan + CHW'(1); // [R1]
      end else begin
        conv_cnt <= conv_cnt + CW'(1);
      end
    end
  end

  // Per-channel filter and comparator
  generate
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign ch_if[g].sample_valid = sample_valid && (sample_chan == CHW'(g)); // [R1]
      assign ch_if[g].sample_data = sample_data;
      assign ch_if[g].filter_en = filter_en;
      assign ch_if[g].filter_clear = filter_clear[g];
      assign ch_if[g].mode = iatm_cmp_mode_t'(comparator_mode_select[g]);
      assign ch_if[g].thr_upper = thr_upper[g]; // [R5]
      assign ch_if[g].thr_lower = thr_lower[g]; // [R5]
      assign raw_a[g] = ch_if[g].raw;
      assign avg_a[g] = ch_if[g].avg;
      assign cross_a[g] = ch_if[g].crossing;
      assign channel_compare_out[g] = ch_if[g].cmp_out; // [R6]

      iatm_chan #(
        .DATA_W(DATA_W),
        .DEPTH(`IATM_AVG_DEPTH)
      ) u_chan (
        .core_clk(core_clk),
        .nrst(nrst),
        .bus(ch_if[g])
      );
    end
  endgenerate

  // Stale-data watch: a channel with no sample for the response time is flagged,
  // since its comparator pin can no longer meet the response figure
  generate
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_watch
      logic [TW-1:0] age;
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          age <= '0;
          sample_timeout[g] <= 1'b0;
        end else if (ch_if[g].sample_valid) begin
          age <= '0;
          sample_timeout[g] <= 1'b0;
        end else if (age == TW'(RESP_CYC)) begin
          sample_timeout[g] <= 1'b1; // [R10]
        end else begin
          age <= age + TW'(1);
        end
      end
    end
  endgenerate

  // Sticky crossing flags; a crossing in the clear cycle still sets the flag
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      crossing_flags <= '0;
    end else begin
      crossing_flags <= (crossing_flags & ~crossing_clear) | cross_a; // [R9]
    end
  end

  // Interrupt pin, active low while any flag stands
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|((crossing_flags & ~crossing_clear) | cross_a); // [R9]
    end
  end

  // Three-stage synchronisers on the serial pins
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync1 <= 3'h2;
      sync2 <= 3'h2;
      sync3 <= 3'h2;
    end else begin
      sync1 <= {spi_sdi, spi_cs_n, spi_sclk};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A pin level is accepted only once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_f <= 3'h2;
      sclk_prev <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sync2[i] == sync3[i]) pin_f[i] <= sync3[i];
      end
      sclk_prev <= pin_f[0];
    end
  end

  assign sclk_rise = pin_f[0] && !sclk_prev;
  assign sclk_fall = !pin_f[0] && sclk_prev;
  assign cs_act = !pin_f[1];
  assign next_rx = {rx_sr[CMD_BITS-2:0], pin_f[2]};

  // Result chosen by the command's channel field, raw or averaged
  assign rd_chan = next_rx[`IATM_CMD_CHAN_LSB +: CHW];
  assign resp_word = {channel_compare_out,
                      filter_en ? avg_a[rd_chan] : raw_a[rd_chan]}; // [R3]

  // Check bytes: one over the outgoing result, one over the received command
  iatm_crc #(
    .W(RESP_BITS)
  ) u_resp_crc (
    .data(resp_word),
    .crc(resp_crc)
  );

  iatm_crc #(
    .W(CMD_BITS)
  ) u_cmd_crc (
    .data(cmd),
    .crc(cmd_crc)
  );

  // Frame length check: a frame must end after the result, or after its check byte
  assign frame_bad = (bit_cnt != BCW'(CMD_BITS + RESP_BITS)) &&
                     (bit_cnt != BCW'(CMD_BITS + TX_BITS));

  // Frame sequencing and receive side, sampled on the rising serial clock
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      spi_state <= SPI_IDLE;
      bit_cnt <= '0;
      rx_sr <= '0;
      cmd <= '0;
      crc_err <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      unique case (spi_state)
        SPI_IDLE: begin
          if (cs_act) begin
            spi_state <= SPI_CMD;
            bit_cnt <= '0;
            crc_err <= 1'b0;
            frame_err <= 1'b0;
          end
        end
        SPI_CMD: begin
          if (!cs_act) begin
            spi_state <= SPI_IDLE;
            frame_err <= 1'b1;
          end else if (sclk_rise) begin
            rx_sr <= next_rx;
            bit_cnt <= bit_cnt + BCW'(1);
            if (bit_cnt == BCW'(CMD_BITS - 1)) begin
              cmd <= next_rx;
              spi_state <= SPI_DATA;
            end
          end
        end
        SPI_DATA: begin
          if (!cs_act) begin
            spi_state <= SPI_IDLE;
            frame_err <= frame_bad;
          end else if (sclk_rise) begin
            rx_sr <= next_rx;
            if (bit_cnt != '1) bit_cnt <= bit_cnt + BCW'(1);
            if (crc_en && bit_cnt == BCW'(CMD_BITS + CRC_BITS - 1)) begin
              crc_err <= next_rx != cmd_crc; // [R11]
            end
          end
        end
      endcase
    end
  end

  // Transmit side: result loaded after the command, shifted on falling edges
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_sr <= '0;
      spi_sdo <= 1'b0;
    end else if (!cs_act) begin
      spi_sdo <= 1'b0;
    end else if (spi_state == SPI_CMD && sclk_rise && bit_cnt == BCW'(CMD_BITS - 1)) begin
      tx_sr <= {resp_word, crc_en ? resp_crc : 8'h00}; // [R11]
    end else if (spi_state == SPI_DATA && sclk_fall) begin
      spi_sdo <= tx_sr[TX_BITS-1]; // [R3]
      tx_sr <= {tx_sr[TX_BITS-2:0], 1'b0};
    end
  end

  // Data pin driven only while the host selects the device
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      spi_sdo_oe <= 1'b0;
    end else begin
      spi_sdo_oe <= cs_act;
    end
  end

endmodule : iatm_top

// ---- iatm_props.sv ----
`timescale 1ns/10ps

module iatm_props #(
  parameter int CONV_CYC = 500
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Converter pacing
  input wire logic conv_req,
  input wire logic [1:0] conv_chan,
  input wire logic sample_valid,
  input wire logic filter_en,
  // Comparator pins and interrupt
  input wire logic [3:0] channel_compare_out,
  input wire logic [3:0] crossing_flags,
  input wire logic [3:0] crossing_clear,
  input wire logic irq_n,
  // Serial port
  input wire logic spi_cs_n,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  int unsigned since;
  logic [3:0] prev_channel_compare_out;
  logic [3:0] moved;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Cycles since last request; a counter, since the real gap is too long to unroll
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      since <= 0;
    end else if (conv_req) begin
      since <= 1;
    end else if (since != 0) begin
      since <= since + 1;
    end
  end

  // Pin levels one cycle back, to tell which channel moved
  always_ff @(posedge core_clk) begin
    prev_channel_compare_out <= channel_compare_out;
  end
  assign moved = channel_compare_out ^ prev_channel_compare_out;

  a_conv_period: assert property (since == CONV_CYC |-> conv_req)
    else $error("conversion request late");
  a_conv_early: assert property (conv_req && since != 0 |-> since == CONV_CYC)
    else $error("conversion request early");
  a_chan_advance: assert property (conv_req |-> conv_chan == $past(conv_chan) + 2'd1)
    else $error("converter channel did not advance");
  a_flag_on_move: assert property (moved != 0 |=> (crossing_flags & $past(moved)) == $past(moved))
    else $error("pin change left no flag");
  a_flag_sticky: assert property ((~crossing_flags & $past(crossing_flags & ~crossing_clear)) == 0)
    else $error("flag dropped without clear");
  a_irq_level: assert property (crossing_flags != 4'h0 |-> !irq_n)
    else $error("interrupt idle with flag set");
  a_irq_cause: assert property ($fell(irq_n) |-> ##[0:1] (crossing_flags != 4'h0))
    else $error("interrupt without flag");
  // Switching the filter swaps the compared value, so it may move a pin with no sample
  a_channel_compare_out_cause: assert property ($changed(channel_compare_out) |->
    $past(sample_valid, 2) || ($past(filter_en) != $past(filter_en, 2)))
    else $error("pin moved without a sample");
  a_oe_select: assert property (!spi_cs_n [*8] |-> spi_sdo_oe)
    else $error("data out not enabled in frame");
  a_oe_release: assert property (spi_cs_n [*8] |-> !spi_sdo_oe && !spi_sdo)
    else $error("data out driven while idle");

  c_conv: cover property (conv_req);
  c_irq: cover property ($fell(irq_n));
  c_frame: cover property ($rose(spi_sdo_oe));
endmodule : iatm_props

bind iatm_top iatm_props #(.CONV_CYC(CONV_CYC)) iatm_props_i (
  .core_clk, .nrst, .conv_req, .conv_chan, .sample_valid, .filter_en, .channel_compare_out,
  .crossing_flags, .crossing_clear, .irq_n, .spi_cs_n, .spi_sdo, .spi_sdo_oe
);

// ---- iatm_spi_host.sv ----
`timescale 1ns/10ps

module iatm_spi_host (
  // Core clock paces the serial clock
  input wire logic core_clk,
  // Serial pins
  output logic spi_sclk = 1'b0,
  output logic spi_cs_n = 1'b1,
  output logic spi_sdi = 1'b0,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  logic crc_ok = 1'b0;

  // Check byte: poly 0x07, init 0xFF, MSB first, no final xor
  function automatic logic [7:0] crc8(input logic [15:0] d, input int n);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = n - 1; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask : hold

  // One frame of n clocks; half period 8 cycles keeps clear of the pin sync
  task automatic xfer(input logic [7:0] cmd, input int n, input logic bad,
                      output logic [15:0] resp);
    logic [31:0] tx;
    logic [31:0] rx;
    tx = {cmd, crc8({8'h00, cmd}, 8) ^ {7'h00, bad}, 16'hA5A5};
    rx = 32'h0000_0000;
    spi_cs_n <= 1'b0;
    hold(8);
    for (int i = 0; i < n; i++) begin
      spi_sdi <= tx[31-i];
      hold(8);
      spi_sclk <= 1'b1;
      // A line the device has let go of reads as garbage, not as its last bit
      rx[31-i] = spi_sdo_oe ? spi_sdo : ~spi_sdo;
      hold(8);
      spi_sclk <= 1'b0;
    end
    hold(8);
    spi_cs_n <= 1'b1;
    spi_sdi <= ~spi_sdi;
    resp = rx[23:8];
    crc_ok = (n == 32) && (rx[7:0] === crc8(rx[23:8], 16));
    hold(8);
  endtask : xfer
endmodule : iatm_spi_host

// ---- test_iatm_top.sv ----
`timescale 1ns/10ps

module test_iatm_top;
  import iatm_pkg::*;

  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic sample_valid = 1'b0;
  logic filter_en = 1'b0;
  logic crc_en = 1'b0;
  logic [1:0] sample_chan = 2'h0;
  iatm_sample_t sample_data = 12'h000;
  logic [3:0] filter_clear = 4'h0;
  logic [3:0] comparator_mode_select = 4'h0;
  logic [3:0] crossing_clear = 4'h0;
  iatm_sample_t [3:0] thr_upper = {4{12'h800}};
  iatm_sample_t [3:0] thr_lower = {4{12'h400}};
  logic conv_req, irq_n, crc_err, frame_err, spi_sdo, spi_sdo_oe;
  logic spi_sclk, spi_cs_n, spi_sdi;
  logic [1:0] conv_chan;
  logic [3:0] channel_compare_out, crossing_flags, sample_timeout;
  logic [3:0] exp_channel_compare_out = 4'h0;
  logic [15:0] resp;
  int err_total = 0;
  int tests_run = 0;

  // Short pacing counts keep the run brief
  iatm_top #(.CONV_CYC(8), .RESP_CYC(40)) iatm_top_i (
    .core_clk, .nrst, .conv_req, .conv_chan, .sample_valid, .sample_chan, .sample_data,
    .filter_en, .filter_clear, .comparator_mode_select, .thr_upper, .thr_lower, .crc_en,
    .channel_compare_out, .crossing_flags, .crossing_clear, .irq_n, .sample_timeout,
    .crc_err, .frame_err, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe
  );
  iatm_spi_host iatm_spi_host_i (
    .core_clk, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe
  );

  always #12.5 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // One sample, then wait until the pin has decided
  task automatic samp(input logic [1:0] ch, input iatm_sample_t v);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    sample_chan <= ch;
    sample_data <= v;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : samp

  // Clear some flags, then compare flags and interrupt
  task automatic clr(input logic [3:0] m, input logic [3:0] left);
    @(posedge core_clk);
    crossing_clear <= m;
    @(posedge core_clk);
    crossing_clear <= 4'h0;
    @(posedge core_clk);
    chk(16'(crossing_flags), 16'(left));
    chk(16'(irq_n), 16'(left == 4'h0));
  endtask : clr

  task automatic rd(input int n, input logic bad, input logic [15:0] exp);
    iatm_spi_host_i.xfer(8'h02, n, bad, resp);
    chk(resp, exp);
  endtask : rd

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
    // Each channel gets its own upper limit; equal to it is not above
    for (int ch = 0; ch < 4; ch++) begin
      thr_upper[ch] <= 12'h700 + 12'(ch);
      samp(2'(ch), 12'h900);
      exp_channel_compare_out[ch] = 1'b1;
      chk(16'(channel_compare_out), 16'(exp_channel_compare_out));
      samp(2'(ch), 12'h600);
      chk(16'(channel_compare_out), 16'(exp_channel_compare_out));
      samp(2'(ch), 12'h3FF);
      exp_channel_compare_out[ch] = 1'b0;
      chk(16'(channel_compare_out), 16'(exp_channel_compare_out));
      samp(2'(ch), 12'h700 + 12'(ch));
      chk(16'(channel_compare_out), 16'(exp_channel_compare_out));
    end
    clr(4'h5, 4'hA);
    clr(4'hA, 4'h0);
    // Status mode follows the upper limit with no hold
    comparator_mode_select <= 4'h1;
    samp(2'd0, 12'h701);
    chk(16'(channel_compare_out), 16'h1);
    samp(2'd0, 12'h650);
    chk(16'(channel_compare_out), 16'h0);
    comparator_mode_select <= 4'h0;
    // Filtered channel: average of four, history zeroed first
    filter_en <= 1'b1;
    filter_clear <= 4'h4;
    @(posedge core_clk);
    filter_clear <= 4'h0;
    for (int k = 0; k < 3; k++) begin
      samp(2'd2, 12'hC00);
      exp_channel_compare_out[2] = (k == 2);
      chk(16'(channel_compare_out), 16'(exp_channel_compare_out));
    end
    samp(2'd2, 12'h100);
    rd(24, 1'b0, {exp_channel_compare_out, 12'((3 * 12'hC00 + 12'h100) >> 2)});
    filter_en <= 1'b0;
    samp(2'd2, 12'h3F0);
    exp_channel_compare_out[2] = 1'b0;
    rd(24, 1'b0, {exp_channel_compare_out, 12'h3F0});
    // Check byte both ways, then a wrong one, then a short frame
    crc_en <= 1'b1;
    rd(32, 1'b0, {exp_channel_compare_out, 12'h3F0});
    chk(16'(iatm_spi_host_i.crc_ok), 16'h1);
    chk(16'(crc_err), 16'h0);
    rd(32, 1'b1, {exp_channel_compare_out, 12'h3F0});
    chk(16'(crc_err), 16'h1);
    crc_en <= 1'b0;
    iatm_spi_host_i.xfer(8'h02, 16, 1'b0, resp);
    chk(16'(frame_err), 16'h1);
    rd(24, 1'b0, {exp_channel_compare_out, 12'h3F0});
    chk(16'(frame_err), 16'h0);
    // Frames ran far past the silence limit on every channel
    chk(16'(sample_timeout), 16'hF);
    samp(2'd1, 12'h3F0);
    chk(16'(sample_timeout), 16'hD);
    end_sim();
  end
endmodule : test_iatm_top
